// file: hw/iomb_exec.sv
// execution core for increment, or, move and branch instructions
//
// Functional notes
// - destination bit picks accumulator or file register
// - file address is seven bits, 0..127
// - increment-skip keeps status, zero adds nop cycle
// - branch loads k and latch page, two cycles
// - branch target field is eleven bits wide
// - or-literal into accumulator, zero flag updated
// - increment stores by destination, updates zero flag
// - or-register routes by destination, updates zero
// - move copies register, updates zero flag
// - move takes one word, one cycle
//
// The implementer's own choices: the plain strobed port and the address map.
`default_nettype none
module iomb_exec (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic busy,
  output logic zero,
  output logic [iomb_pkg::PC_W-1:0] pc
);
  import iomb_pkg::*;
  // -------------------------------------------------------------------
  // submodules
  // -------------------------------------------------------------------
  iomb_dec_if u_if ();
  iomb_decode u_decode (
    .dbus(u_if.dec)
  );
  iomb_alu u_alu (
    .abus(u_if.alu)
  );
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  iomb_state_t state_ff;
  iomb_state_t nxt_state;
  logic [7:0] instr_lo_ff;
  logic [7:0] w_ff;
  logic zero_ff;
  logic skip_ff;
  logic busy_ff;
  logic [PC_W-1:0] pc_ff;
  logic [7:0] latch_ff;
  logic [7:0] cycles_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic [7:0] file_ff [0:127];
  logic exec;
  logic file_op;
  logic skip_taken;
  logic two_cycle;
  logic to_file;
  logic to_accum;
  logic bus_file_wr;
  logic file_we;
  logic [6:0] file_waddr;
  logic [7:0] file_wdata;
  assign u_if.instr = {wr_data[5:0], instr_lo_ff};
  assign u_if.w = w_ff;
  assign u_if.fval = file_ff[u_if.faddr];
  // -------------------------------------------------------------------
  // execution control
  // -------------------------------------------------------------------
  // a write to the high instruction byte issues it; refused while busy
  assign exec = wr_en && (addr == ADDR_INSTR_HI) && (state_ff == ST_RUN);
  assign file_op = (u_if.op == OP_INC_SKIP) || (u_if.op == OP_INC) ||
                   (u_if.op == OP_OR_REG) || (u_if.op == OP_MOVE);
  assign skip_taken = exec && (u_if.op == OP_INC_SKIP) && u_if.res_zero;
  assign two_cycle = skip_taken || (exec && (u_if.op == OP_BRANCH));
  assign to_file = exec && file_op && (u_if.dest == DEST_FILE);
  assign to_accum = exec && ((file_op && (u_if.dest == DEST_ACCUM)) || (u_if.op == OP_OR_LIT));
  assign bus_file_wr = wr_en && addr[7];
  assign file_we = to_file || bus_file_wr;
  assign file_waddr = to_file ? u_if.faddr : addr[6:0];
  assign file_wdata = to_file ? u_if.res : wr_data;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (two_cycle) begin
          nxt_state = ST_SECOND;
        end
      end
      ST_SECOND: nxt_state = ST_RUN;
      default: nxt_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_RUN;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state == ST_SECOND);
    end
  end
  // -------------------------------------------------------------------
  // instruction low byte
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_lo_ff <= RST_BYTE;
    end else if (wr_en && (addr == ADDR_INSTR_LO)) begin
      instr_lo_ff <= wr_data;
    end
  end
  // -------------------------------------------------------------------
  // accumulator
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_ff <= RST_BYTE;
    end else if (to_accum) begin
      w_ff <= u_if.res;
    end else if (wr_en && (addr == ADDR_ACCUM)) begin
      w_ff <= wr_data;
    end
  end
  // -------------------------------------------------------------------
  // status flags
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_ff <= 1'b0;
      skip_ff <= 1'b0;
    end else begin
      if (exec && u_if.upd_zero) begin
        zero_ff <= u_if.res_zero;
      end else if (wr_en && (addr == ADDR_STATUS)) begin
        zero_ff <= wr_data[STAT_ZERO_BIT];
      end
      if (exec) begin
        skip_ff <= skip_taken;
      end
    end
  end
  // -------------------------------------------------------------------
  // program counter and upper latch
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff <= RST_PC;
    end else if (exec) begin
      if (u_if.op == OP_BRANCH) begin
        pc_ff <= {latch_ff[LATCH_PAGE_HI:LATCH_PAGE_LO], u_if.target};
      end else if (skip_taken) begin
        pc_ff <= pc_ff + PC_SKIP_STEP;
      end else begin
        pc_ff <= pc_ff + PC_STEP;
      end
    end else if (wr_en && (addr == ADDR_PC_LO)) begin
      pc_ff <= {pc_ff[12:8], wr_data};
    end else if (wr_en && (addr == ADDR_PC_HI)) begin
      pc_ff <= {wr_data[4:0], pc_ff[7:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_ff <= RST_BYTE;
    end else if (wr_en && (addr == ADDR_UPPER_LATCH)) begin
      latch_ff <= wr_data;
    end
  end
  // -------------------------------------------------------------------
  // instruction cycle counter
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycles_ff <= RST_BYTE;
    end else if (exec || (state_ff == ST_SECOND)) begin
      cycles_ff <= cycles_ff + CYCLE_STEP;
    end
  end
  // -------------------------------------------------------------------
  // file registers
  // -------------------------------------------------------------------
  for (genvar gi = 0; gi < 128; gi++) begin : g_file
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        file_ff[gi] <= RST_BYTE;
      end else if (file_we && (file_waddr == 7'(gi))) begin
        file_ff[gi] <= file_wdata;
      end
    end
  end
  // -------------------------------------------------------------------
  // read port
  // -------------------------------------------------------------------
  always_comb begin
    nxt_rd_data = RST_BYTE;
    if (rd_en) begin
      if (addr[7]) begin
        nxt_rd_data = file_ff[addr[6:0]];
      end else begin
        case (addr)
          ADDR_INSTR_LO: nxt_rd_data = instr_lo_ff;
          ADDR_ACCUM: nxt_rd_data = w_ff;
          ADDR_STATUS: nxt_rd_data = {5'h00, skip_ff, busy_ff, zero_ff};
          ADDR_PC_LO: nxt_rd_data = pc_ff[7:0];
          ADDR_PC_HI: nxt_rd_data = {3'h0, pc_ff[12:8]};
          ADDR_UPPER_LATCH: nxt_rd_data = latch_ff;
          ADDR_CYCLES: nxt_rd_data = cycles_ff;
          default: nxt_rd_data = RST_BYTE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= RST_BYTE;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;
  assign busy = busy_ff;
  assign zero = zero_ff;
  assign pc = pc_ff;
  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_DEST_ACCUM: assert property (
    exec && file_op && (u_if.dest == DEST_ACCUM) |=> (w_ff == $past(u_if.res)) && (file_ff[$past(u_if.faddr)] ==
      $past(u_if.fval)))
    else $error("file op with accumulator destination misrouted");
  AST_DEST_FILE: assert property (
    exec && file_op && (u_if.dest == DEST_FILE) |=> (file_ff[$past(u_if.faddr)] == $past(u_if.res)) &&
      (w_ff == $past(w_ff)))
    else $error("file op with file destination misrouted");
  AST_SKIP_TWO: assert property (
    exec && (u_if.op == OP_INC_SKIP) && (u_if.fval == 8'hFF) |=> busy_ff && skip_ff ##1 !busy_ff)
    else $error("zero increment-skip did not take two cycles");
  AST_SKIP_STATUS: assert property (
    exec && (u_if.op == OP_INC_SKIP) |=> $stable(zero_ff))
    else $error("increment-skip changed the zero flag");
  AST_BRANCH_PC: assert property (
    exec && (u_if.op == OP_BRANCH) |=> busy_ff && (pc_ff == {$past(latch_ff[4:3]), $past(u_if.instr[10:0])})
      ##1 !busy_ff && $stable(pc_ff))
    else $error("branch target or cycle count wrong");
  AST_OR_LIT: assert property (
    exec && (u_if.op == OP_OR_LIT) |=> (w_ff == ($past(w_ff) | $past(instr_lo_ff))))
    else $error("or-literal result wrong");
  AST_MOVE_ONE: assert property (
    exec && (u_if.op == OP_MOVE) |=> !busy_ff && (pc_ff == $past(pc_ff) + PC_STEP))
    else $error("move did not complete in one cycle");
  AST_ZERO_FLAG: assert property (
    exec && u_if.upd_zero |=> (zero_ff == ($past(u_if.res) == 8'h00)))
    else $error("zero flag does not match result");
  AST_INC_WRAP: assert property (
    exec && (u_if.op == OP_INC) && (u_if.fval == 8'hFF) |=> zero_ff)
    else $error("increment of all ones did not wrap to zero");

  // -------------------------------------------------------------------
  // checks: operand fields and routing
  // -------------------------------------------------------------------
  AST_FADDR_FIELD: assert property (
    exec && file_op |->
      (u_if.fval == file_ff[u_if.instr[FADDR_W-1:0]]))
    else $error("file operand not taken from the low seven bits");
  AST_BRANCH_LOW: assert property (
    exec && (u_if.op == OP_BRANCH) |=>
      (pc_ff[TARGET_W-1:0] == $past(u_if.instr[TARGET_W-1:0])))
    else $error("branch low target bits wrong");
  AST_BRANCH_PAGE: assert property (
    exec && (u_if.op == OP_BRANCH) |=>
      (pc_ff[PC_W-1:TARGET_W] == $past(latch_ff[LATCH_PAGE_HI:LATCH_PAGE_LO])))
    else $error("branch page bits wrong");
  AST_INC_FILE: assert property (
    exec && (u_if.op == OP_INC) && (u_if.dest == DEST_FILE) |=>
      (file_ff[$past(u_if.faddr)] == 8'($past(u_if.fval) + 8'h01)))
    else $error("increment not written back to the file register");
  AST_INC_ACCUM: assert property (
    exec && (u_if.op == OP_INC) && (u_if.dest == DEST_ACCUM) |=>
      (w_ff == 8'($past(u_if.fval) + 8'h01)))
    else $error("increment not written to the accumulator");
  AST_OR_REG_FILE: assert property (
    exec && (u_if.op == OP_OR_REG) && (u_if.dest == DEST_FILE) |=>
      (file_ff[$past(u_if.faddr)] == ($past(w_ff) | $past(u_if.fval))))
    else $error("or-register not written back to the file register");
  AST_OR_REG_ACCUM: assert property (
    exec && (u_if.op == OP_OR_REG) && (u_if.dest == DEST_ACCUM) |=>
      (w_ff == ($past(w_ff) | $past(u_if.fval))))
    else $error("or-register not written to the accumulator");
  AST_MOVE_COPY: assert property (
    exec && (u_if.op == OP_MOVE) |=>
      ($past(u_if.dest) ? (file_ff[$past(u_if.faddr)] == $past(u_if.fval)) : (w_ff == $past(u_if.fval))))
    else $error("move did not copy the file register");
  AST_SKIP_FILE_WRAP: assert property (
    exec && (u_if.op == OP_INC_SKIP) && (u_if.fval == 8'hFF) && (u_if.dest == DEST_FILE) |=>
      (file_ff[$past(u_if.faddr)] == 8'h00))
    else $error("increment-skip of all ones did not wrap to zero");

  // -------------------------------------------------------------------
  // checks: zero flag
  // -------------------------------------------------------------------
  AST_INC_ZERO: assert property (
    exec && (u_if.op == OP_INC) |=>
      (zero_ff == ($past(u_if.fval) == 8'hFF)))
    else $error("increment zero flag wrong");
  AST_OR_LIT_ZERO: assert property (
    exec && (u_if.op == OP_OR_LIT) |=>
      (zero_ff == (($past(w_ff) | $past(instr_lo_ff)) == 8'h00)))
    else $error("or-literal zero flag wrong");
  AST_OR_REG_ZERO: assert property (
    exec && (u_if.op == OP_OR_REG) |=>
      (zero_ff == (($past(w_ff) | $past(u_if.fval)) == 8'h00)))
    else $error("or-register zero flag wrong");
  AST_MOVE_ZERO: assert property (
    exec && (u_if.op == OP_MOVE) |=>
      (zero_ff == ($past(u_if.fval) == 8'h00)))
    else $error("move zero flag wrong");
  AST_BRANCH_STATUS: assert property (
    exec && (u_if.op == OP_BRANCH) |=>
      $stable(zero_ff))
    else $error("branch changed the zero flag");

  // -------------------------------------------------------------------
  // checks: cycle timing
  // -------------------------------------------------------------------
  AST_SKIP_PC: assert property (
    skip_taken |=>
      (pc_ff == $past(pc_ff) + PC_SKIP_STEP))
    else $error("taken skip did not pass over the next word");
  AST_NOSKIP_ONE: assert property (
    exec && (u_if.op == OP_INC_SKIP) && !u_if.res_zero |=>
      !busy_ff && !skip_ff && (pc_ff == $past(pc_ff) + PC_STEP))
    else $error("non-zero increment-skip did not take one cycle");
  AST_BUSY_ONE: assert property (
    busy_ff |=>
      !busy_ff)
    else $error("extra cycle lasted more than one cycle");
  AST_REFUSE_BUSY: assert property (
    wr_en && (addr == ADDR_INSTR_HI) && busy_ff |=>
      $stable(w_ff) && $stable(pc_ff))
    else $error("instruction issued during the extra cycle was executed");
endmodule : iomb_exec
`default_nettype wire

// file: hw/iomb_pkg.sv
// constants and types shared by the instruction execution block
`default_nettype none
package iomb_pkg;
  // -------------------------------------------------------------------
  // register map of the plain software port
  // -------------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR_LO = 8'h00;
  localparam logic [7:0] ADDR_INSTR_HI = 8'h01;
  localparam logic [7:0] ADDR_ACCUM = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_PC_LO = 8'h04;
  localparam logic [7:0] ADDR_PC_HI = 8'h05;
  localparam logic [7:0] ADDR_UPPER_LATCH = 8'h06;
  localparam logic [7:0] ADDR_CYCLES = 8'h07;
  localparam logic [7:0] ADDR_FILE_BASE = 8'h80;
  // -------------------------------------------------------------------
  // status fields
  // -------------------------------------------------------------------
  localparam int STAT_ZERO_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_SKIP_BIT = 2;
  // -------------------------------------------------------------------
  // instruction word layout and opcodes
  // -------------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int FADDR_W = 7;
  localparam int TARGET_W = 11;
  localparam int PC_W = 13;
  localparam int DEST_BIT = 7;
  localparam int LATCH_PAGE_HI = 4;
  localparam int LATCH_PAGE_LO = 3;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
  localparam logic [5:0] OPC_INC = 6'h0A;
  localparam logic [5:0] OPC_OR_REG = 6'h04;
  localparam logic [5:0] OPC_MOVE = 6'h08;
  localparam logic [5:0] OPC_OR_LIT = 6'h38;
  localparam logic [2:0] OPC_BRANCH = 3'h5;
  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // -------------------------------------------------------------------
  // reset values and step sizes
  // -------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic [12:0] PC_STEP = 13'h0001;
  localparam logic [12:0] PC_SKIP_STEP = 13'h0002;
  localparam logic [7:0] CYCLE_STEP = 8'h01;
  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_INC_SKIP = 3'h1,
    OP_INC = 3'h2,
    OP_BRANCH = 3'h3,
    OP_OR_LIT = 3'h4,
    OP_OR_REG = 3'h5,
    OP_MOVE = 3'h6
  } iomb_op_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SECOND = 2'b10
  } iomb_state_t;
endpackage : iomb_pkg
`default_nettype wire

// file: hw/iomb_dec_if.sv
// carrier between the core, the decoder and the arithmetic unit
`default_nettype none
interface iomb_dec_if;
  import iomb_pkg::*;
  logic [13:0] instr;
  iomb_op_t op;
  logic dest;
  logic [6:0] faddr;
  logic [7:0] lit;
  logic [10:0] target;
  logic upd_zero;
  logic [7:0] w;
  logic [7:0] fval;
  logic [7:0] res;
  logic res_zero;
  modport core (output instr, w, fval, input op, dest, faddr, lit, target, upd_zero, res, res_zero);
  modport dec (input instr, output op, dest, faddr, lit, target, upd_zero);
  modport alu (input op, lit, w, fval, output res, res_zero);
endinterface : iomb_dec_if
`default_nettype wire

// file: hw/iomb_decode.sv
// instruction word decoder
`default_nettype none
module iomb_decode (
  iomb_dec_if.dec dbus
);
  import iomb_pkg::*;
  // -------------------------------------------------------------------
  // field split
  // -------------------------------------------------------------------
  assign dbus.dest = dbus.instr[DEST_BIT];
  assign dbus.faddr = dbus.instr[FADDR_W-1:0];
  assign dbus.lit = dbus.instr[7:0];
  assign dbus.target = dbus.instr[TARGET_W-1:0];
  // -------------------------------------------------------------------
  // opcode match
  // -------------------------------------------------------------------
  always_comb begin
    dbus.op = OP_NONE;
    if (dbus.instr[13:11] == OPC_BRANCH) begin
      dbus.op = OP_BRANCH;
    end else begin
      case (dbus.instr[13:8])
        OPC_INC_SKIP: dbus.op = OP_INC_SKIP;
        OPC_INC: dbus.op = OP_INC;
        OPC_OR_REG: dbus.op = OP_OR_REG;
        OPC_MOVE: dbus.op = OP_MOVE;
        OPC_OR_LIT: dbus.op = OP_OR_LIT;
        default: dbus.op = OP_NONE;
      endcase
    end
  end
  // skip variant and branch leave status alone
  assign dbus.upd_zero = (dbus.op == OP_INC) || (dbus.op == OP_OR_LIT) ||
                         (dbus.op == OP_OR_REG) || (dbus.op == OP_MOVE);
endmodule : iomb_decode
`default_nettype wire

// file: hw/iomb_alu.sv
// eight-bit result path
`default_nettype none
module iomb_alu (
  iomb_dec_if.alu abus
);
  import iomb_pkg::*;
  always_comb begin
    case (abus.op)
      OP_INC_SKIP, OP_INC: abus.res = 8'(abus.fval + 8'h01);
      OP_OR_LIT: abus.res = abus.w | abus.lit;
      OP_OR_REG: abus.res = abus.w | abus.fval;
      OP_MOVE: abus.res = abus.fval;
      default: abus.res = RST_BYTE;
    endcase
  end
  assign abus.res_zero = (abus.res == 8'h00);
endmodule : iomb_alu
`default_nettype wire

// file: bench/iomb_exec_tb.sv
// self-checking bench for the increment, or, move and branch execution core
`default_nettype none
module iomb_exec_tb import iomb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst_n;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_data;
  logic busy;
  logic zero;
  logic [PC_W-1:0] pc;
  int error_cnt = 0;
  int total_checks = 0;
  logic [12:0] exp_pc = 13'h0000;
  logic [7:0] exp_cyc = 8'h00;
  logic [7:0] lat_v = 8'h00;

  iomb_exec u_iomb_exec (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .busy(busy), .zero(zero), .pc(pc));

  always #25 clk = ~clk;

  // -------------------------------------------------------------------
  // bus and check helpers
  // -------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(nm, {8'h00, e}, {8'h00, rd_data});
  endtask : rdc

  task automatic zchk(input logic e);
    chk("zero", {15'h0000, e}, {15'h0000, zero});
  endtask : zchk

  task automatic setf(input logic [6:0] f, input logic [7:0] v);
    wr(ADDR_FILE_BASE | {1'b0, f}, v);
  endtask : setf

  task automatic setlat(input logic [7:0] v);
    wr(ADDR_UPPER_LATCH, v);
    lat_v = v;
  endtask : setlat

  // issues one instruction and follows its one or two cycles
  task automatic exec(input logic [13:0] i, input logic two);
    wr(ADDR_INSTR_LO, i[7:0]);
    wr(ADDR_INSTR_HI, {2'b00, i[13:8]});
    if (i[13:11] == OPC_BRANCH) begin
      exp_pc = {lat_v[4:3], i[10:0]};
    end else begin
      exp_pc = exp_pc + (two ? 13'h0002 : 13'h0001);
    end
    exp_cyc = exp_cyc + (two ? 8'h02 : 8'h01);
    #1;
    chk("busy", {15'h0000, two}, {15'h0000, busy});
    chk("pc", {3'h0, exp_pc}, {3'h0, pc});
    if (two) begin
      @(posedge clk);
      #1;
      chk("busy_end", 16'h0000, {15'h0000, busy});
    end
  endtask : exec

  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    chk("pc_rst", 16'h0000, {3'h0, pc});
    zchk(1'b0);
    rdc(ADDR_ACCUM, 8'h00, "accum_rst");
    rdc(8'hFF, 8'h00, "file127_rst");
    rdc(8'h40, 8'h00, "unmapped");
  endtask : t_reset

  task automatic t_inc();
    setf(7'h05, 8'h41);
    exec({OPC_INC, 1'b1, 7'h05}, 1'b0);
    rdc(8'h85, 8'h42, "inc_file");
    zchk(1'b0);
    setf(7'h7F, 8'hFF);
    wr(ADDR_ACCUM, 8'h33);
    exec({OPC_INC, 1'b0, 7'h7F}, 1'b0);
    rdc(ADDR_ACCUM, 8'h00, "inc_wrap");
    rdc(8'hFF, 8'hFF, "inc_keep");
    zchk(1'b1);
  endtask : t_inc

  task automatic t_skip();
    wr(ADDR_STATUS, 8'h00);
    setf(7'h00, 8'hFF);
    exec({OPC_INC_SKIP, 1'b1, 7'h00}, 1'b1);
    rdc(8'h80, 8'h00, "skip_file");
    zchk(1'b0);
    rdc(ADDR_STATUS, 8'h04, "skip_stat");
    wr(ADDR_STATUS, 8'h01);
    setf(7'h03, 8'h05);
    wr(ADDR_ACCUM, 8'h00);
    exec({OPC_INC_SKIP, 1'b0, 7'h03}, 1'b0);
    rdc(ADDR_ACCUM, 8'h06, "noskip_acc");
    rdc(8'h83, 8'h05, "noskip_file");
    zchk(1'b1);
  endtask : t_skip

  task automatic t_branch();
    wr(ADDR_STATUS, 8'h01);
    setlat(8'hE7);
    exec({OPC_BRANCH, 11'h7FF}, 1'b1);
    setlat(8'h18);
    exec({OPC_BRANCH, 11'h123}, 1'b1);
    zchk(1'b1);
    rdc(ADDR_CYCLES, exp_cyc, "cycles");
  endtask : t_branch

  task automatic t_or();
    wr(ADDR_ACCUM, 8'h00);
    exec({OPC_OR_LIT, 8'h00}, 1'b0);
    zchk(1'b1);
    wr(ADDR_ACCUM, 8'h50);
    exec({OPC_OR_LIT, 8'h0A}, 1'b0);
    rdc(ADDR_ACCUM, 8'h5A, "or_lit");
    zchk(1'b0);
    setf(7'h0A, 8'h81);
    exec({OPC_OR_REG, 1'b1, 7'h0A}, 1'b0);
    rdc(8'h8A, 8'hDB, "or_reg_file");
    rdc(ADDR_ACCUM, 8'h5A, "or_reg_acc");
    wr(ADDR_ACCUM, 8'h00);
    setf(7'h0B, 8'h00);
    exec({OPC_OR_REG, 1'b0, 7'h0B}, 1'b0);
    zchk(1'b1);
  endtask : t_or

  task automatic t_move();
    wr(ADDR_STATUS, 8'h00);
    setf(7'h14, 8'h00);
    exec({OPC_MOVE, 1'b1, 7'h14}, 1'b0);
    zchk(1'b1);
    rdc(8'h94, 8'h00, "mov_self");
    setf(7'h15, 8'h9C);
    wr(ADDR_ACCUM, 8'h00);
    exec({OPC_MOVE, 1'b0, 7'h15}, 1'b0);
    rdc(ADDR_ACCUM, 8'h9C, "mov_acc");
    zchk(1'b0);
    rdc(ADDR_CYCLES, exp_cyc, "mov_cycles");
  endtask : t_move

  task automatic t_pc_nop();
    wr(ADDR_PC_LO, 8'h34);
    wr(ADDR_PC_HI, 8'h1A);
    exp_pc = 13'h1A34;
    rdc(ADDR_PC_HI, 8'h1A, "pc_hi");
    rdc(ADDR_PC_LO, 8'h34, "pc_lo");
    wr(ADDR_ACCUM, 8'h20);
    exec(14'h0000, 1'b0);
    rdc(ADDR_ACCUM, 8'h20, "nop_acc");
    @(posedge clk);
    #1;
    chk("rd_idle", 16'h0000, {8'h00, rd_data});
  endtask : t_pc_nop

  // a second instruction offered in the extra cycle of a branch is dropped
  task automatic t_refuse();
    setlat(8'h00);
    wr(ADDR_INSTR_LO, 8'h55);
    @(posedge clk);
    addr <= ADDR_INSTR_HI;
    wr_data <= {2'b00, OPC_BRANCH, 3'h0};
    wr_en <= 1'b1;
    @(posedge clk);
    wr_data <= {2'b00, OPC_OR_LIT};
    @(posedge clk);
    wr_en <= 1'b0;
    exp_pc = 13'h0055;
    exp_cyc = exp_cyc + 8'h02;
    #1;
    chk("refused_pc", {3'h0, exp_pc}, {3'h0, pc});
    rdc(ADDR_ACCUM, 8'h20, "refused_acc");
    rdc(ADDR_CYCLES, exp_cyc, "refused_cycles");
  endtask : t_refuse

  task automatic end_sim();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // -------------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_inc();
    t_skip();
    t_branch();
    t_or();
    t_move();
    t_pc_nop();
    t_refuse();
    end_sim();
  end

  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule : iomb_exec_tb
`default_nettype wire
